// ---- dtm_pkg.sv ----
// Constants and types shared by the dual timer mode control block.
// How it works
// RULE1: Timer one gated by pin one when gating set.
// RULE2: Gating clear: timer one runs on run bit.
// RULE3: Timer zero gating mirrors timer one.
// RULE4: Source select picks system clock or pin.
// RULE5: Software keeps source select zero for PWM.
// RULE6: Mode 00: high byte fed by prescaler.
// RULE7: Mode 01: sixteen bit count, reload on overflow.
// RULE8: Mode 10: low byte reloads from high byte.
// RULE9: Mode 11: timer one holds its count.
// RULE10: Timer zero modes 00-10 match timer one.
// RULE11: Timer zero split: high byte uses timer one.
// RULE12: Timer one PWM enable drives count pin.
// RULE13: Timer zero PWM enable drives count pin.
// RULE14: Timer one prescaler width is field plus one.
// RULE15: Timer zero prescaler width is field plus one.
// RULE16: Timer one prescale field resets to 100B.
// RULE17: Timer zero prescale field resets to 100B.
// RULE18: PWM and prescale register resets to 24h.
// RULE19: Mode register resets to zero.
// RULE20: Overflow sets flag; vectoring clears it.
// RULE21: Prescaler wrap increments the high byte.
package dtm_pkg;
  localparam logic [7:0] IDX_RUN = 8'h88;
  localparam logic [7:0] IDX_MODE = 8'h89;
  localparam logic [7:0] IDX_LO0 = 8'h8a;
  localparam logic [7:0] IDX_HI0 = 8'h8c;
  localparam logic [7:0] IDX_PWMPSC = 8'h91;
  localparam logic [7:0] IDX_RLO0 = 8'h92;
  localparam logic [7:0] IDX_RHI0 = 8'h94;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PWMPSC_RST = 8'h24;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ZERO = 8'h00;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [2:0] PSC_MAX = 3'h7;
  localparam int NIB_W = 4;
  localparam int FLD_SRC = 2;
  localparam int FLD_GATE = 3;
  localparam int PSC_W = 3;
  localparam int PWM_EN_LSB = 6;
  localparam int RUN_LSB = 4;
  localparam int FLAG_OFS = 1;
  typedef enum logic [1:0] {
    MODE_VAR = 2'h0,
    MODE_AR16 = 2'h1,
    MODE_AR8 = 2'h2,
    MODE_HOLD = 2'h3
  } dtm_mode_e;
endpackage : dtm_pkg

// ---- dtm_timer_ctrl.sv ----
// Two timer/counters with mode, gating, prescale and PWM control on Wishbone.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dtm_timer_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_irq_pin_zero_i,
  input wire logic ext_irq_pin_one_i,
  input wire logic timer_zero_count_pin_i,
  output logic timer_zero_count_pin_o,
  output logic timer_zero_count_pin_oe_o,
  input wire logic timer_one_count_pin_i,
  output logic timer_one_count_pin_o,
  output logic timer_one_count_pin_oe_o,
  input wire logic timer_zero_vector_ack_i,
  input wire logic timer_one_vector_ack_i,
  output logic timer_zero_overflow_flag_o,
  output logic timer_one_overflow_flag_o
);
  // One counting step, given that the timer ticks: {overflow, high, low}.
  function automatic logic [16:0] dtm_step(
    input logic [1:0] m,
    input logic [2:0] psc,
    input logic split,
    input logic [7:0] lo,
    input logic [7:0] hi,
    input logic [7:0] rlo,
    input logic [7:0] rhi
  );
    logic [7:0] mask;
    logic [16:0] r;
    mask = dtm_pkg::ALL_ONES >> (dtm_pkg::PSC_MAX - psc); // RULE14 RULE15
    r = {1'b0, hi, lo};
    case (m)
      dtm_pkg::MODE_VAR: begin
        if ((lo & mask) == mask) begin
          r[7:0] = lo & ~mask; // RULE21
          r[15:8] = hi + dtm_pkg::ONE; // RULE6 RULE10
          r[16] = (hi == dtm_pkg::ALL_ONES);
        end else begin
          r[7:0] = (lo & ~mask) | ((lo + dtm_pkg::ONE) & mask);
        end
      end
      dtm_pkg::MODE_AR16: begin
        if ({hi, lo} == {dtm_pkg::ALL_ONES, dtm_pkg::ALL_ONES}) begin
          r = {1'b1, rhi, rlo}; // RULE7 RULE10
        end else begin
          r[15:0] = {hi, lo} + {dtm_pkg::ZERO, dtm_pkg::ONE};
        end
      end
      dtm_pkg::MODE_AR8: begin
        if (lo == dtm_pkg::ALL_ONES) begin
          r[7:0] = hi; // RULE8 RULE10
          r[16] = 1'b1;
        end else begin
          r[7:0] = lo + dtm_pkg::ONE;
        end
      end
      default: begin
        if (split) begin
          r[7:0] = lo + dtm_pkg::ONE; // RULE11
          r[16] = (lo == dtm_pkg::ALL_ONES);
        end
      end
    endcase
    return r;
  endfunction : dtm_step

  logic [7:0] mode_q;
  logic [7:0] pwmpsc_q;
  logic [1:0] run_q;
  logic [1:0] flag_q;
  logic [7:0] lo_q [2];
  logic [7:0] hi_q [2];
  logic [7:0] rlo_q [2];
  logic [7:0] rhi_q [2];
  logic [7:0] ocr_q [2];
  logic [1:0] pwm_q;
  logic [1:0] irq_m_q;
  logic [1:0] irq_s_q;
  logic [1:0] pin_m_q;
  logic [1:0] pin_s_q;
  logic [1:0] pin_p_q;
  logic ack_q;
  logic [7:0] dat_q;
  logic [7:0] rd_d;

  wire logic [7:0] idx;
  wire logic req;
  wire logic wr_stb;
  wire logic wr_run;
  wire logic wr_mode;
  wire logic wr_pwmpsc;
  wire logic split0;
  wire logic th_ovf;
  wire logic [1:0] irq_pin;
  wire logic [1:0] cnt_pin;
  wire logic [1:0] vack;
  wire logic [1:0] pin_fall;
  wire logic [1:0] gate;
  wire logic [1:0] src;
  wire logic [1:0] pwm_en;
  wire logic [1:0] en;
  wire logic [1:0] tick;
  wire logic [1:0] ev;
  wire logic [1:0] set;
  wire logic [1:0] alt;
  wire logic [1:0] hi_tk;
  wire logic [1:0] wr_lo;
  wire logic [1:0] wr_hi;
  wire logic [1:0] wr_rlo;
  wire logic [1:0] wr_rhi;
  wire logic [1:0] mode [2];
  wire logic [2:0] psc [2];
  wire logic [16:0] nxt [2];
  wire logic [7:0] hi_nx [2];

  // Pin groups and bus decode; a write lands on the edge where ack is high.
  assign irq_pin = {ext_irq_pin_one_i, ext_irq_pin_zero_i};
  assign cnt_pin = {timer_one_count_pin_i, timer_zero_count_pin_i};
  assign vack = {timer_one_vector_ack_i, timer_zero_vector_ack_i};
  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_stb = req & wb_we_i & ack_q & wb_sel_i[0];
  assign wr_run = wr_stb & (idx == dtm_pkg::IDX_RUN);
  assign wr_mode = wr_stb & (idx == dtm_pkg::IDX_MODE);
  assign wr_pwmpsc = wr_stb & (idx == dtm_pkg::IDX_PWMPSC);
  assign split0 = (mode[0] == dtm_pkg::MODE_HOLD);
  assign th_ovf = split0 & en[1] & (hi_q[0] == dtm_pkg::ALL_ONES);
  assign wb_ack_o = ack_q;
  assign wb_dat_o = {24'h000000, dat_q};

  // Per-timer control decode, count enables and next values.
  for (genvar i = 0; i < 2; i++) begin : g_dec
    assign mode[i] = mode_q[i*dtm_pkg::NIB_W +: 2];
    assign src[i] = mode_q[i*dtm_pkg::NIB_W + dtm_pkg::FLD_SRC];
    assign gate[i] = mode_q[i*dtm_pkg::NIB_W + dtm_pkg::FLD_GATE];
    assign psc[i] = pwmpsc_q[i*dtm_pkg::PSC_W +: dtm_pkg::PSC_W];
    assign pwm_en[i] = pwmpsc_q[dtm_pkg::PWM_EN_LSB + i];
    assign pin_fall[i] = pin_p_q[i] & ~pin_s_q[i];
    assign en[i] = run_q[i] & (~gate[i] | irq_s_q[i]); // RULE1 RULE2 RULE3
    // The pin feeds counting only with source set; PWM users keep it clear.
    assign tick[i] = en[i] & (~src[i] | pin_fall[i]); // RULE4 RULE5
    assign nxt[i] = dtm_step(mode[i], psc[i], split0 & (i == 0),
                             lo_q[i], hi_q[i], rlo_q[i], rhi_q[i]);
    assign ev[i] = tick[i] & nxt[i][16];
    assign alt[i] = split0 & (i == 0);
    assign hi_tk[i] = alt[i] ? en[1] : tick[i]; // RULE11
    assign hi_nx[i] = alt[i] ? hi_q[i] + dtm_pkg::ONE : nxt[i][15:8];
    assign wr_lo[i] = wr_stb & (idx == dtm_pkg::IDX_LO0 + 8'(i));
    assign wr_hi[i] = wr_stb & (idx == dtm_pkg::IDX_HI0 + 8'(i));
    assign wr_rlo[i] = wr_stb & (idx == dtm_pkg::IDX_RLO0 + 8'(i));
    assign wr_rhi[i] = wr_stb & (idx == dtm_pkg::IDX_RHI0 + 8'(i));
  end

  // Timer one loses its flag to the split high byte of timer zero.
  assign set[0] = ev[0];
  assign set[1] = split0 ? th_ovf : ev[1]; // RULE11 RULE20

  // Two-stage synchronisers, plus one more stage for pin edge detection.
  always_ff @(posedge clk_i) begin
    irq_m_q <= irq_pin;
    irq_s_q <= irq_m_q;
    pin_m_q <= cnt_pin;
    pin_s_q <= pin_m_q;
    pin_p_q <= pin_s_q;
  end

  // Control registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= dtm_pkg::MODE_RST; // RULE19
      pwmpsc_q <= dtm_pkg::PWMPSC_RST; // RULE16 RULE17 RULE18
      run_q <= 2'h0;
    end else begin
      if (wr_mode) begin
        mode_q <= wb_dat_i[7:0];
      end
      if (wr_pwmpsc) begin
        pwmpsc_q <= wb_dat_i[7:0];
      end
      if (wr_run) begin
        run_q <= {wb_dat_i[dtm_pkg::RUN_LSB + 2], wb_dat_i[dtm_pkg::RUN_LSB]};
      end
    end
  end

  // Counters, reloads, flags and PWM outputs of each timer.
  for (genvar i = 0; i < 2; i++) begin : g_tmr
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        lo_q[i] <= dtm_pkg::CNT_RST;
        hi_q[i] <= dtm_pkg::CNT_RST;
      end else begin
        if (wr_lo[i]) begin
          lo_q[i] <= wb_dat_i[7:0];
        end else if (tick[i]) begin
          lo_q[i] <= nxt[i][7:0]; // RULE9
        end
        if (wr_hi[i]) begin
          hi_q[i] <= wb_dat_i[7:0];
        end else if (hi_tk[i]) begin
          hi_q[i] <= hi_nx[i];
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        rlo_q[i] <= dtm_pkg::CNT_RST;
        rhi_q[i] <= dtm_pkg::CNT_RST;
      end else begin
        if (wr_rlo[i]) begin
          rlo_q[i] <= wb_dat_i[7:0];
        end
        if (wr_rhi[i]) begin
          rhi_q[i] <= wb_dat_i[7:0];
        end
      end
    end

    // A fresh overflow wins over a clear in the same cycle.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        flag_q[i] <= 1'b0;
      end else begin
        flag_q[i] <= set[i] | (flag_q[i] & ~vack[i]); // RULE20
      end
    end

    // Compare value is taken at overflow so duty changes stay glitch free.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ocr_q[i] <= dtm_pkg::CNT_RST;
        pwm_q[i] <= 1'b0;
      end else if (!pwm_en[i]) begin
        pwm_q[i] <= 1'b0;
      end else if (mode[i] == dtm_pkg::MODE_AR8) begin
        pwm_q[i] <= pwm_q[i] ^ ev[i];
      end else if (ev[i] && mode[i] != dtm_pkg::MODE_HOLD) begin
        ocr_q[i] <= rhi_q[i];
        pwm_q[i] <= (rhi_q[i] != dtm_pkg::ZERO);
      end else if (hi_q[i] == ocr_q[i]) begin
        pwm_q[i] <= 1'b0;
      end
    end
  end

  // Pin drivers: the enable follows the PWM enable bits.
  assign timer_zero_count_pin_o = pwm_q[0]; // RULE13
  assign timer_zero_count_pin_oe_o = pwm_en[0]; // RULE13
  assign timer_one_count_pin_o = pwm_q[1]; // RULE12
  assign timer_one_count_pin_oe_o = pwm_en[1]; // RULE12
  assign timer_zero_overflow_flag_o = flag_q[0];
  assign timer_one_overflow_flag_o = flag_q[1];

  // Read decode; unmapped addresses read as zero.
  always_comb begin
    rd_d = dtm_pkg::ZERO;
    if (idx == dtm_pkg::IDX_RUN) begin
      rd_d = {flag_q[1], run_q[1], flag_q[0], run_q[0], 4'h0};
    end else if (idx == dtm_pkg::IDX_MODE) begin
      rd_d = mode_q;
    end else if (idx == dtm_pkg::IDX_PWMPSC) begin
      rd_d = pwmpsc_q;
    end else if (idx == dtm_pkg::IDX_LO0) begin
      rd_d = lo_q[0];
    end else if (idx == dtm_pkg::IDX_LO0 + dtm_pkg::ONE) begin
      rd_d = lo_q[1];
    end else if (idx == dtm_pkg::IDX_HI0) begin
      rd_d = hi_q[0];
    end else if (idx == dtm_pkg::IDX_HI0 + dtm_pkg::ONE) begin
      rd_d = hi_q[1];
    end else if (idx == dtm_pkg::IDX_RLO0) begin
      rd_d = rlo_q[0];
    end else if (idx == dtm_pkg::IDX_RLO0 + dtm_pkg::ONE) begin
      rd_d = rlo_q[1];
    end else if (idx == dtm_pkg::IDX_RHI0) begin
      rd_d = rhi_q[0];
    end else if (idx == dtm_pkg::IDX_RHI0 + dtm_pkg::ONE) begin
      rd_d = rhi_q[1];
    end
  end

  // Bus answer one cycle after the request; read data is latched with it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= dtm_pkg::ZERO;
    end else begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q) begin
        dat_q <= rd_d;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Timer one prescaler wrap in the reset width of five bits.
  sequence s_wrap1;
    mode[1] == dtm_pkg::MODE_VAR && psc[1] == 3'h4 && tick[1]
      && lo_q[1][4:0] == 5'h1f && !wr_lo[1] && !wr_hi[1];
  endsequence

  a_gate_one_blocks: assert property ( // RULE1
    (gate[1] && !irq_s_q[1] && !wr_lo[1] && !wr_hi[1])
      |=> $stable(lo_q[1]) && $stable(hi_q[1]))
    else $error("gated timer one moved");
  a_free_one_runs: assert property ( // RULE2
    (!gate[1] && run_q[1] && !src[1] && mode[1] == dtm_pkg::MODE_AR16
      && !wr_lo[1] && !wr_hi[1] && {hi_q[1], lo_q[1]} != 16'hffff)
      |=> {hi_q[1], lo_q[1]} == $past({hi_q[1], lo_q[1]}) + 16'h0001)
    else $error("ungated timer one failed to count");
  a_pin_source_zero: assert property ( // RULE4
    (src[0] && !pin_fall[0] && !wr_lo[0] && !split0) |=> $stable(lo_q[0]))
    else $error("counter source moved without a pin edge");
  a_prescale_wrap: assert property ( // RULE6 RULE14 RULE21
    s_wrap1 |=> hi_q[1] == $past(hi_q[1]) + 8'h01 && lo_q[1][4:0] == 5'h00)
    else $error("prescaler wrap did not step high byte");
  a_reload_sixteen: assert property ( // RULE7
    (mode[1] == dtm_pkg::MODE_AR16 && tick[1] && !split0 && lo_q[1] == 8'hff
      && hi_q[1] == 8'hff && !wr_lo[1] && !wr_hi[1])
      |=> lo_q[1] == $past(rlo_q[1]) && hi_q[1] == $past(rhi_q[1]) && flag_q[1])
    else $error("sixteen bit reload wrong");
  a_reload_eight: assert property ( // RULE8 RULE10
    (mode[0] == dtm_pkg::MODE_AR8 && tick[0] && lo_q[0] == 8'hff && !wr_lo[0])
      |=> lo_q[0] == $past(hi_q[0]) && flag_q[0])
    else $error("eight bit reload wrong");
  a_one_holds: assert property ( // RULE9
    (mode[1] == dtm_pkg::MODE_HOLD && !wr_lo[1] && !wr_hi[1])
      |=> $stable({hi_q[1], lo_q[1]}))
    else $error("timer one moved in mode three");
  a_split_high: assert property ( // RULE11
    (split0 && en[1] && !wr_hi[0]) |=> hi_q[0] == $past(hi_q[0]) + 8'h01)
    else $error("split high byte did not follow timer one");
  a_pwm_drive: assert property ( // RULE12 RULE13
    (wr_pwmpsc && wb_dat_i[7] && !wb_dat_i[6])
      |=> timer_one_count_pin_oe_o && !timer_zero_count_pin_oe_o)
    else $error("PWM enables do not steer the pins");
  a_reset_values: assert property ( // RULE16 RULE17 RULE18 RULE19
    $past(rst_i) |-> pwmpsc_q == 8'h24 && mode_q == 8'h00 && !pwm_q[0])
    else $error("register reset values wrong");
  a_flag_set_wins: assert property ( // RULE20
    (set[0] && vack[0]) |=> flag_q[0])
    else $error("overflow lost against a clear");

  // Timer zero gating, pin counting, flag clearing and bus answer checks.
  a_gate_zero_blocks: assert property ( // RULE3
    (gate[0] && !irq_s_q[0] && !wr_lo[0] && !wr_hi[0] && !split0)
      |=> $stable(lo_q[0]) && $stable(hi_q[0]))
    else $error("gated timer zero moved");
  a_pin_edge_counts: assert property ( // RULE4
    (src[0] && en[0] && pin_fall[0] && mode[0] == dtm_pkg::MODE_AR8
      && lo_q[0] != 8'hff && !wr_lo[0])
      |=> lo_q[0] == $past(lo_q[0]) + 8'h01)
    else $error("pin edge was not counted");
  a_flag_clears: assert property ( // RULE20
    (flag_q[0] && vack[0] && !set[0]) |=> !flag_q[0])
    else $error("vector acknowledge left the flag set");
  a_ack_single: assert property (
    ack_q |=> !ack_q)
    else $error("bus answer held longer than one cycle");
  a_mode_write_lands: assert property (
    wr_mode |=> mode_q == $past(wb_dat_i[7:0]))
    else $error("mode register write lost");
endmodule : dtm_timer_ctrl
`default_nettype wire

// ---- dual_timer_mode_control_tb_top.sv ----
// Self-checking bench for the dual timer mode control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module dual_timer_mode_control_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic ack;
  logic [1:0] irq = 2'b00, cpin = 2'b11, vack = 2'b00, po, oe, flg, pin_w;
  logic [7:0] rv;
  logic [15:0] q[$];
  int checks = 0;
  int fail_count = 0;

  // The count pins are two-way: the block drives them while its PWM output is enabled.
  assign pin_w = (oe & po) | (~oe & cpin);

  always #20 clk_i = ~clk_i;

  dtm_timer_ctrl i_dtm_timer_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .ext_irq_pin_zero_i(irq[0]),
    .ext_irq_pin_one_i(irq[1]), .timer_zero_count_pin_i(pin_w[0]),
    .timer_zero_count_pin_o(po[0]), .timer_zero_count_pin_oe_o(oe[0]),
    .timer_one_count_pin_i(pin_w[1]), .timer_one_count_pin_o(po[1]),
    .timer_one_count_pin_oe_o(oe[1]), .timer_zero_vector_ack_i(vack[0]),
    .timer_one_vector_ack_i(vack[1]), .timer_zero_overflow_flag_o(flg[0]),
    .timer_one_overflow_flag_o(flg[1]));

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // One classic Wishbone cycle; read data is taken at the edge that sees ack.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    dat <= {24'h0, d};
    sel <= 4'h1;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rv = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  // Notes the expected byte and mask, then reads.
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    q.push_back({m, e});
    bus(1'b0, a, 8'h00);
  endtask : rd

  // Falling edges on a count pin, slow enough for the input synchroniser.
  task automatic edges(input int t, input int n);
    repeat (n) begin
      @(posedge clk_i);
      cpin[t] <= 1'b0;
      repeat (4) @(posedge clk_i);
      cpin[t] <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
  endtask : edges

  task automatic vec(input int t);
    @(posedge clk_i);
    vack[t] <= 1'b1;
    @(posedge clk_i);
    vack[t] <= 1'b0;
  endtask : vec

  // Takes the oldest note whenever read data is answered and compares it.
  always @(posedge clk_i) begin
    logic [15:0] n;
    if (ack === 1'b1 && we === 1'b0) begin
      if (q.size() == 0) begin
        fail_count++;
        $display("[ERR] %0t read answered with no note", $time);
      end else begin
        n = q.pop_front();
        `CHK(dat_o[7:0] & n[15:8], n[7:0] & n[15:8])
      end
    end
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    summarize();
  end

  initial begin
    logic [7:0] ti, r, lo, m, rb, fb;
    logic [15:0] r16;
    logic [2:0] p;
    void'($urandom(3));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h89, 8'h00, 8'hff);
    rd(8'h91, 8'h24, 8'hff);
    rd(8'h88, 8'h00, 8'hff);
    rd(8'h00, 8'h00, 8'hff);
    `CHK(oe, 2'b00)
    $display("test reset done");
    for (int t = 0; t < 2; t++) begin
      ti = 8'(t);
      rb = 8'h10 << (2 * t);
      fb = 8'h20 << (2 * t);
      // Eight-bit auto-reload counting pin edges.
      r = 8'($urandom_range(0, 254));
      wr(8'h89, 8'h06 << (4 * t));
      wr(8'h8c + ti, r);
      wr(8'h8a + ti, 8'hfe);
      wr(8'h88, rb);
      repeat (10) @(posedge clk_i);
      rd(8'h8a + ti, 8'hfe, 8'hff);
      edges(t, 3);
      rd(8'h8a + ti, r + 8'h01, 8'hff);
      rd(8'h8c + ti, r, 8'hff);
      rd(8'h88, rb | fb, 8'hff);
      vec(t);
      rd(8'h88, rb, 8'hff);
      // Sixteen-bit auto-reload.
      r16 = 16'($urandom_range(0, 65534));
      wr(8'h89, 8'h05 << (4 * t));
      wr(8'h92 + ti, r16[7:0]);
      wr(8'h94 + ti, r16[15:8]);
      wr(8'h8a + ti, 8'hfe);
      wr(8'h8c + ti, 8'hff);
      edges(t, 3);
      r16 = r16 + 16'h0001;
      rd(8'h8a + ti, r16[7:0], 8'hff);
      rd(8'h8c + ti, r16[15:8], 8'hff);
      vec(t);
      // Variable width: one edge wraps exactly the active prescaler bits.
      p = 3'($urandom_range(0, 7));
      m = 8'(~(32'hff << (p + 1)));
      wr(8'h91, 8'(p) << (3 * t));
      wr(8'h89, 8'h04 << (4 * t));
      wr(8'h8a + ti, m | (8'ha5 & ~m));
      wr(8'h8c + ti, 8'hff);
      edges(t, 1);
      rd(8'h8a + ti, 8'h00, m);
      rd(8'h8c + ti, 8'h00, 8'hff);
      rd(8'h88, rb | fb, 8'hff);
      vec(t);
      if (t == 1) begin
        wr(8'h89, 8'h70);
        wr(8'h8b, 8'h10);
        edges(1, 2);
        rd(8'h8b, 8'h10, 8'hff);
      end
      // Pin gating on the internal clock.
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h09 << (4 * t));
      wr(8'h8a + ti, 8'h00);
      wr(8'h8c + ti, 8'h00);
      wr(8'h88, rb);
      repeat (10) @(posedge clk_i);
      rd(8'h8a + ti, 8'h00, 8'hff);
      irq[t] <= 1'b1;
      repeat (10) @(posedge clk_i);
      rd(8'h8a + ti, 8'h00, 8'h00);
      `CHK(rv !== 8'h00, 1'b1)
      irq[t] <= 1'b0;
      wr(8'h89, 8'h01 << (4 * t));
      rd(8'h8a + ti, 8'h00, 8'h00);
      r = rv;
      rd(8'h8a + ti, 8'h00, 8'h00);
      `CHK(rv !== r, 1'b1)
      $display("test timer %0d done", t);
    end
    // Split mode: high byte of timer zero runs on timer one's run bit.
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h03);
    wr(8'h8a, 8'h00);
    wr(8'h8c, 8'h00);
    wr(8'h91, 8'h24);
    wr(8'h8b, 8'h1c);
    wr(8'h88, 8'h40);
    repeat (10) @(posedge clk_i);
    rd(8'h8a, 8'h00, 8'hff);
    rd(8'h8c, 8'h00, 8'h00);
    `CHK(rv !== 8'h00, 1'b1)
    $display("test split done");
    // Overflow every cycle while the vector acknowledge is held: the flag stays set.
    wr(8'h89, 8'h02);
    wr(8'h8c, 8'hff);
    wr(8'h8a, 8'hff);
    wr(8'h88, 8'h10);
    vack[0] <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(8'h88, 8'h30, 8'h30);
    vack[0] <= 1'b0;
    $display("test flag done");
    // PWM enables take over the count pins; both source selects stay clear.
    wr(8'h88, 8'h00);
    wr(8'h91, 8'he4);
    repeat (2) @(posedge clk_i);
    `CHK(oe, 2'b11)
    rd(8'h91, 8'he4, 8'hff);
    wr(8'h91, 8'ha4);
    repeat (2) @(posedge clk_i);
    `CHK(oe, 2'b10)
    wr(8'h91, 8'h64);
    repeat (2) @(posedge clk_i);
    `CHK(oe, 2'b01)
    wr(8'h91, 8'h24);
    repeat (2) @(posedge clk_i);
    `CHK(oe, 2'b00)
    $display("test pwm done");
    repeat (4) @(posedge clk_i);
    summarize();
  end
endmodule : dual_timer_mode_control_tb_top
`undef CHK
`default_nettype wire
